// ---- rtl/bpcs_peak_regs.v ----
// peak-current setting registers 0x00 to 0x03 of the dual buck driver
`timescale 1ns/1ps
`include "bpcs_regs.vh"
// Summary of operation
// - idle register always reads zero whatever was written
// - in daisy-chain mode writing all ones to idle register selects star mode
// - channel-one setpoint is bits 8..0 of 0x01, bit 9 reads zero
// - channel-two setpoint is bits 8..0 of 0x02, bit 9 reads zero
// - peak current scales linearly with code; range doubles the current
// - channel-one range codes 000..100 mean ranges one to five
// - channel-one range becomes active only on next channel-one setpoint write
// - channel-one bit allows low-side pre-driver at low LED voltage
// - channel-two bit allows low-side pre-driver at low LED voltage
// - channel-two range codes 000..100 mean ranges one to five
// - channel-two range becomes active only on next channel-two setpoint write
module bpcs_peak_regs (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // register access from the serial front end, same clock
    input  wire [4:0] reg_addr,
    input  wire       reg_wr,
    input  wire [9:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [9:0] reg_rdata,
    // serial interface mode
    input  wire       daisy_mode,
    output wire       star_mode_req,
    // analog controls
    output reg  [8:0] ch1_peak_setpoint,
    output reg  [8:0] ch2_peak_setpoint,
    output wire [2:0] ch1_range_select,
    output wire [2:0] ch2_range_select,
    output reg        ch1_lowside_lowvolt_enable,
    output reg        ch2_lowside_lowvolt_enable,
    // active range code is beyond range five, set on the setpoint write that activates it
    output wire       ch1_range_invalid,
    output wire       ch2_range_invalid
);
    // write strobes, one per mapped register
    wire       wr_idle;
    wire       wr_ch1;
    wire       wr_ch2;
    wire       wr_range;

    // both channels side by side, channel one in the low slice
    wire [1:0] setpoint_we_all;
    wire [5:0] range_field_all;
    wire [5:0] range_shadow_all;
    wire [5:0] range_active_all;
    wire [1:0] range_invalid_all;

    // channel copies of the shadow, for readback only
    wire [2:0] ch1_range_shadow;
    wire [2:0] ch2_range_shadow;

    // read multiplexer output, registered on a read strobe
    reg  [9:0] next_rdata;

    // address decode for writes
    function addr_hit;
        input [4:0] a;
        input [4:0] target;
        begin
            addr_hit = (a == target);
        end
    endfunction

    assign wr_idle  = reg_wr && addr_hit(reg_addr, `BPCS_ADDR_IDLE);
    assign wr_ch1   = reg_wr && addr_hit(reg_addr, `BPCS_ADDR_CH1_PEAK);
    assign wr_ch2   = reg_wr && addr_hit(reg_addr, `BPCS_ADDR_CH2_PEAK);
    assign wr_range = reg_wr && addr_hit(reg_addr, `BPCS_ADDR_RANGE);

    // one-cycle request to the serial front end; it owns the mode itself
    assign star_mode_req = wr_idle && daisy_mode
                           && (reg_wdata == `BPCS_IDLE_ALL_ONES);

    // setpoints; bit 9 of the written word is not stored, so it reads zero
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch1_peak_setpoint <= `BPCS_SETPOINT_RESET;
            ch2_peak_setpoint <= `BPCS_SETPOINT_RESET;
        end
        else
        begin
            if (wr_ch1)
            begin
                ch1_peak_setpoint <= reg_wdata[`BPCS_SETPOINT_MSB:`BPCS_SETPOINT_LSB];
            end
            if (wr_ch2)
            begin
                ch2_peak_setpoint <= reg_wdata[`BPCS_SETPOINT_MSB:`BPCS_SETPOINT_LSB];
            end
        end
    end

    // low-voltage enables act at once; unlike the range they need no shadow
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch1_lowside_lowvolt_enable <= `BPCS_LOWV_RESET;
            ch2_lowside_lowvolt_enable <= `BPCS_LOWV_RESET;
        end
        else if (wr_range)
        begin
            ch1_lowside_lowvolt_enable <= reg_wdata[`BPCS_CH1_LOWV_BIT];
            ch2_lowside_lowvolt_enable <= reg_wdata[`BPCS_CH2_LOWV_BIT];
        end
    end

    // per-channel strobes and fields gathered so one loop serves both
    assign setpoint_we_all = {wr_ch2, wr_ch1};
    assign range_field_all = {reg_wdata[`BPCS_CH2_RANGE_MSB:`BPCS_CH2_RANGE_LSB],
                              reg_wdata[`BPCS_CH1_RANGE_MSB:`BPCS_CH1_RANGE_LSB]};

    // codes above range five have no meaning for the current sense
    function code_unlisted;
        input [2:0] code;
        begin
            code_unlisted = (code > `BPCS_RANGE_MAX);
        end
    endfunction

    // range shadows; the analog side sees only the active copy
    // both channels share the range strobe, each has its own setpoint strobe
    genvar g;
    generate
        for (g = 0; g < `BPCS_CHANNELS; g = g + 1)
        begin : gen_chan
            wire [2:0] field;
            wire [2:0] pending;
            reg        unlisted;

            assign field = range_field_all[g*`BPCS_RANGE_W +: `BPCS_RANGE_W];

            bpcs_range_shadow u_range (
                .core_clk     (core_clk),
                .rst_n        (rst_n),
                .range_we     (wr_range),
                .range_wdata  (field),
                .setpoint_we  (setpoint_we_all[g]),
                .range_shadow (range_shadow_all[g*`BPCS_RANGE_W +: `BPCS_RANGE_W]),
                .range_active (range_active_all[g*`BPCS_RANGE_W +: `BPCS_RANGE_W])
            );

            // the range a setpoint write would activate in this cycle;
            // range and setpoint never share a cycle, the mux keeps it exact anyway
            assign pending = wr_range ? field
                                      : range_shadow_all[g*`BPCS_RANGE_W +: `BPCS_RANGE_W];

            // flag kept beside the active copy so both change on one edge;
            // codes five to seven are stored, so a bad host write shows, not hides
            always @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    unlisted <= `BPCS_FLAG_RESET;
                end
                else if (setpoint_we_all[g])
                begin
                    unlisted <= code_unlisted(pending);
                end
            end

            assign range_invalid_all[g] = unlisted;
        end
    endgenerate

    // channel one sits in the low slice of each gathered bus
    assign ch1_range_shadow  = range_shadow_all[`BPCS_RANGE_W-1:0];
    assign ch2_range_shadow  = range_shadow_all[2*`BPCS_RANGE_W-1:`BPCS_RANGE_W];
    assign ch1_range_select  = range_active_all[`BPCS_RANGE_W-1:0];
    assign ch2_range_select  = range_active_all[2*`BPCS_RANGE_W-1:`BPCS_RANGE_W];

    // unlisted codes are passed on unchanged but flagged
    assign ch1_range_invalid = range_invalid_all[0];
    assign ch2_range_invalid = range_invalid_all[1];

    // read multiplexer; idle and unmapped addresses return zero
    // a read in the same cycle as a write returns the old contents
    always @*
    begin
        next_rdata = `BPCS_DATA_ZERO;
        if (addr_hit(reg_addr, `BPCS_ADDR_CH1_PEAK))
        begin
            next_rdata = {`BPCS_FIXED_ZERO_ONE, ch1_peak_setpoint};
        end
        else if (addr_hit(reg_addr, `BPCS_ADDR_CH2_PEAK))
        begin
            next_rdata = {`BPCS_FIXED_ZERO_ONE, ch2_peak_setpoint};
        end
        else if (addr_hit(reg_addr, `BPCS_ADDR_RANGE))
        begin
            // readback shows the written shadow, not the active range
            next_rdata = {`BPCS_FIXED_ZERO_TWO, ch1_lowside_lowvolt_enable,
                          ch2_lowside_lowvolt_enable, ch1_range_shadow,
                          ch2_range_shadow};
        end
        else
        begin
            next_rdata = `BPCS_DATA_ZERO;
        end
    end

    // read data held until the next read strobe
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= `BPCS_DATA_ZERO;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// ---- rtl/bpcs_regs.vh ----
// register offsets, field positions and reset values of the peak-current bank
`ifndef BPCS_REGS_VH
`define BPCS_REGS_VH
`define BPCS_ADDR_IDLE        5'h00
`define BPCS_ADDR_CH1_PEAK    5'h01
`define BPCS_ADDR_CH2_PEAK    5'h02
`define BPCS_ADDR_RANGE       5'h03
`define BPCS_DATA_ZERO        10'h000
`define BPCS_IDLE_ALL_ONES    10'h3FF
`define BPCS_SETPOINT_RESET   9'h000
`define BPCS_RANGE_RESET      3'h0
`define BPCS_RANGE_MAX        3'h4
`define BPCS_SETPOINT_MSB     8
`define BPCS_CH1_LOWV_BIT     7
`define BPCS_CH2_LOWV_BIT     6
`define BPCS_CH1_RANGE_MSB    5
`define BPCS_CH1_RANGE_LSB    3
`define BPCS_CH2_RANGE_MSB    2
`define BPCS_CH2_RANGE_LSB    0
`define BPCS_SETPOINT_LSB     0
`define BPCS_RANGE_W          3
`define BPCS_CHANNELS         2
`define BPCS_LOWV_RESET       1'b0
`define BPCS_FLAG_RESET       1'b0
`define BPCS_FIXED_ZERO_ONE   1'b0
`define BPCS_FIXED_ZERO_TWO   2'b00
`endif

// ---- rtl/bpcs_range_shadow.v ----
// one channel's range selector with its shadow and active copies
`timescale 1ns/1ps
`include "bpcs_regs.vh"
module bpcs_range_shadow (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // register writes
    input  wire       range_we,
    input  wire [2:0] range_wdata,
    input  wire       setpoint_we,
    // copies
    output reg  [2:0] range_shadow,
    output reg  [2:0] range_active
);
    // a write of the setpoint in the same cycle as the range takes the new range
    wire [2:0] next_shadow;
    assign next_shadow = range_we ? range_wdata : range_shadow;

    // shadow follows software, active follows only on a setpoint write
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            range_shadow <= `BPCS_RANGE_RESET;
            range_active <= `BPCS_RANGE_RESET;
        end
        else
        begin
            range_shadow <= next_shadow;
            if (setpoint_we)
            begin
                range_active <= next_shadow;
            end
        end
    end
endmodule

// ---- tb/bpcs_props.sv ----
// concurrent checks on the peak-current register bank
`timescale 1ns/1ps
module bpcs_props (
    // watched ports
    input wire       core_clk,
    input wire       rst_n,
    input wire [4:0] reg_addr,
    input wire       reg_wr,
    input wire [9:0] reg_wdata,
    input wire       reg_rd,
    input wire [9:0] reg_rdata,
    input wire       daisy_mode,
    input wire       star_mode_req,
    input wire [8:0] ch1_peak_setpoint,
    input wire [8:0] ch2_peak_setpoint,
    input wire [2:0] ch1_range_select,
    input wire [2:0] ch2_range_select,
    input wire       ch1_lowside_lowvolt_enable,
    input wire       ch2_lowside_lowvolt_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // strobes per register, star request condition
    wire w1 = reg_wr && reg_addr == 5'h01;
    wire w2 = reg_wr && reg_addr == 5'h02;
    wire w3 = reg_wr && reg_addr == 5'h03;
    wire st = reg_wr && reg_addr == 5'h00 && reg_wdata == 10'h3FF && daisy_mode;
    // written fields as plain signals for $past
    wire [8:0] wsp  = reg_wdata[8:0];
    wire       wlv1 = reg_wdata[7];
    wire       wlv2 = reg_wdata[6];
    // last written range fields, what a setpoint write must activate
    reg  [2:0] sh1, sh2;
    always @(posedge core_clk or negedge rst_n)
        if (!rst_n) {sh1, sh2} <= 6'h00;
        else if (w3) {sh1, sh2} <= reg_wdata[5:0];
    a_idle_zero: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata == 10'h000)
        else $error("idle read");
    a_star_pulse: assert property (star_mode_req == st)
        else $error("star");
    a_ch1_set: assert property (w1 |=> ch1_peak_setpoint == $past(wsp))
        else $error("sp1");
    a_ch2_set: assert property (w2 |=> ch2_peak_setpoint == $past(wsp))
        else $error("sp2");
    a_ch1_hold: assert property (!w1 |=> $stable(ch1_range_select))
        else $error("rs1");
    a_ch2_hold: assert property (!w2 |=> $stable(ch2_range_select))
        else $error("rs2");
    a_ch1_lowv: assert property (w3 |=> ch1_lowside_lowvolt_enable == $past(wlv1))
        else $error("lv1");
    a_ch2_lowv: assert property (w3 |=> ch2_lowside_lowvolt_enable == $past(wlv2))
        else $error("lv2");
    a_ch1_range: assert property (w1 |=> ch1_range_select == $past(sh1))
        else $error("ra1");
    a_ch2_range: assert property (w2 |=> ch2_range_select == $past(sh2))
        else $error("ra2");
    c_star: cover property (star_mode_req);
    c_rng: cover property (w3 ##[1:8] w1);
    c_rd: cover property (reg_rd && reg_addr == 5'h03);
endmodule
bind bpcs_peak_regs bpcs_props bpcs_props_i (.*);

// ---- tb/bpcs_host.sv ----
// host model issuing register accesses
`timescale 1ns/1ps
module bpcs_host (
    // clock
    input  wire       core_clk,
    // requests
    output reg  [4:0] reg_addr,
    output reg        reg_wr,
    output reg  [9:0] reg_wdata,
    output reg        reg_rd
);
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 17'h00000;
    // one-cycle strobe; released address and data show inverted values, never the stale ones; both strobes go low
    task acc(input [4:0] a, input [9:0] d, input w);
        @(posedge core_clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
        @(posedge core_clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {~a, ~d, 2'b00};
    endtask
endmodule

// ---- tb/bpcs_peak_regs_bench.sv ----
// self-checking bench for the peak-current register bank
`timescale 1ns/1ps
module bpcs_peak_regs_bench;
    reg        core_clk, rst_n, daisy_mode, rd_q;
    wire [4:0] reg_addr;
    wire       reg_wr, reg_rd, star_mode_req, lv1, lv2, inv1, inv2;
    wire [9:0] reg_wdata, reg_rdata;
    wire [8:0] sp1, sp2;
    wire [2:0] rs1, rs2;
    integer    n_errors, compares, n_star, i;
    reg [31:0] s;
    reg [9:0]  q[$];
    reg [9:0]  d, p;
    bpcs_host bpcs_host_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    bpcs_peak_regs bpcs_peak_regs_i (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .daisy_mode(daisy_mode), .star_mode_req(star_mode_req),
        .ch1_peak_setpoint(sp1), .ch2_peak_setpoint(sp2), .ch1_range_select(rs1),
        .ch2_range_select(rs2), .ch1_lowside_lowvolt_enable(lv1),
        .ch2_lowside_lowvolt_enable(lv2), .ch1_range_invalid(inv1), .ch2_range_invalid(inv2));
    task check(input [9:0] v, input [9:0] e);
        compares = compares + 1;
        if (v !== e)
        begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %h not %h", $time, v, e);
        end
    endtask
    function [31:0] xorshift(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xorshift = y ^ (y << 5);
        end
    endfunction
    task results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input [4:0] a, input [9:0] v); bpcs_host_i.acc(a, v, 1'b1); endtask
    task rd(input [4:0] a, input [9:0] e); q.push_back(e); bpcs_host_i.acc(a, 10'h000, 1'b0); endtask
    // read data lands one cycle after the strobe; star pulses counted mid-cycle
    always @(posedge core_clk) rd_q <= reg_rd;
    always @(negedge core_clk)
    begin
        if (rd_q === 1'b1) check(reg_rdata, q.pop_front());
        if (star_mode_req === 1'b1) n_star = n_star + 1;
    end
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        #100000 n_errors = n_errors + 1;
        results;
    end
    initial
    begin
        {rst_n, daisy_mode, n_errors, compares, n_star, p} = 0;
        s = 32'h537845D5;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1) rd(i[4:0], 10'h000);
        for (i = 0; i < 8; i = i + 1)
        begin
            s = xorshift(s);
            wr(5'h01 + i[0], s[9:0] | 10'h200);
            rd(5'h01 + i[0], {1'b0, s[8:0]});
        end
        $display("setpoint test done");
        // range written first, then setpoints; codes above four avoided
        for (i = 0; i < 5; i = i + 1)
        begin
            s = xorshift(s);
            d = {2'b00, i[0], ~i[0], i[2:0], 3'h4 - i[2:0]};
            wr(5'h03, d | 10'h300);
            rd(5'h03, d);
            @(negedge core_clk);
            check({2'b00, rs1, rs2, lv1, lv2}, {2'b00, p[5:0], d[7:6]});
            wr(5'h01, s[9:0]);
            @(negedge core_clk);
            check({4'h0, rs1, rs2}, {4'h0, d[5:3], p[2:0]});
            wr(5'h02, s[9:0]);
            @(negedge core_clk);
            check({4'h0, rs1, rs2}, d & 10'h03F);
            check({8'h00, inv1, inv2}, 10'h000);
            p = d & 10'h03F;
        end
        $display("range test done");
        @(posedge core_clk);
        daisy_mode <= 1'b1;
        wr(5'h00, 10'h3FE);
        wr(5'h00, 10'h3FF);
        rd(5'h00, 10'h000);
        daisy_mode <= 1'b0;
        wr(5'h00, 10'h3FF);
        rd(5'h1F, 10'h000);
        repeat (2) @(negedge core_clk);
        check(n_star[9:0], 10'h001);
        $display("idle test done");
        results;
    end
endmodule
